/* File: include/adc_trig_cfg.svh */
`ifndef ADC_TRIG_CFG_SVH
`define ADC_TRIG_CFG_SVH
// Overview of operation
// - With timer triggering in single-channel single-conversion mode, any write to conv_control_first that leaves the enable set starts a sample.
// - The intended arming path is setting conversion_enable_bit, which arms the next capture trigger in single-conversion mode.
// - In the sequence and repeat modes a trigger that arrives while busy halts all further conversions until a write clears power_on.
// - A conversion starts from software_start_bit or from the selected timer trigger.
// - The conversion timer overflow flag is unreliable and nothing in the logic depends on it except irq, when its mask bit is set.
// - Switching the clock source away from subsystem_master_clock while its gate-off bit is set stops the converter.
// - That hang happens only with conv_clock_divider at divide by three, five or seven.
// - A hung converter recovers only through a reset.

// ==========================================
// Register offsets
`define OFS_CTRL_FIRST 8'h00
`define OFS_CTRL_SECOND 8'h04
`define OFS_FLAGS 8'h08
`define OFS_MASK 8'h0c
`define OFS_RESULT 8'h10
`define OFS_STATUS 8'h14
`define OFS_CLOCK_SYS 8'h18

// ==========================================
// Field positions
`define BIT_ENABLE 0
`define BIT_SW_START 1
`define BIT_POWER_ON 2
`define BIT_SAMPLE_TIMER 3
`define BIT_BUSY_MIRROR 8
`define SUBSYS_CLOCK_SEL 2'h3

// ==========================================
// Reset values and timing
`define RST_CTRL_FIRST 3'h0
`define RST_CTRL_SECOND 7'h00
`define RST_FLAGS 4'h0
`define LAST_CHANNEL 4'h3
`define CONV_TICKS 5'h10
`endif

/* File: include/adc_trig_pkg.sv */
package adc_trig_pkg;

    typedef enum logic {ST_IDLE, ST_CONV} conv_state_e;

    typedef enum logic [1:0] {
        SEQ_SINGLE,
        SEQ_CHANNELS,
        SEQ_REPEAT_SINGLE,
        SEQ_REPEAT_CHANNELS
    } seq_mode_e;

    typedef struct packed {
        logic sample_timer;
        logic power_on;
        logic enable;
    } ctrl_first_s;

    typedef struct packed {
        logic [2:0] divider;
        logic [1:0] clock_select;
        seq_mode_e seq_mode;
    } ctrl_second_s;

    typedef struct packed {
        logic hang;
        logic halt;
        logic overflow;
        logic done;
    } flags_s;

endpackage

/* File: verilog/sync_two.sv */
`timescale 1ns/1ns
module sync_two #(
    parameter int WIDTH = 1
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic [WIDTH-1:0] d, // Asynchronous input
    output logic [WIDTH-1:0] q // Synchronised output
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* File: verilog/adc_conversion_trigger_control.sv */
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "adc_trig_cfg.svh"
module adc_conversion_trigger_control
    import adc_trig_pkg::*;
(
    input wire logic pclk, // APB clock, 10 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic timer_trigger, // Timer output pin
    input wire logic [11:0] sample_in, // Digitised sample pins
    output logic conv_busy, // Conversion in progress
    output logic irq // Level interrupt
);

    // ==========================================
    // Pin synchronisers
    // Only the second flop of each pair feeds logic; the sample word settles long before use
    logic timer_sync;
    logic [11:0] sample_sync;

    sync_two #(.WIDTH(1)) u_sync_trig (
        .pclk(pclk),
        .presetn(presetn),
        .d(timer_trigger),
        .q(timer_sync)
    );

    sync_two #(.WIDTH(12)) u_sync_sample (
        .pclk(pclk),
        .presetn(presetn),
        .d(sample_in),
        .q(sample_sync)
    );

    // ==========================================
    // State
    ctrl_first_s ctrl_first;
    ctrl_first_s next_ctrl_first;
    ctrl_second_s ctrl_second;
    ctrl_second_s next_ctrl_second;
    flags_s flags;
    flags_s next_flags;
    flags_s mask;
    flags_s next_mask;
    conv_state_e state;
    conv_state_e next_state;
    logic gate_off;
    logic next_gate_off;
    logic armed;
    logic next_armed;
    logic halted;
    logic next_halted;
    logic hung;
    logic next_hung;
    logic timer_prev;
    logic [2:0] div_cnt;
    logic [2:0] next_div_cnt;
    logic [4:0] tick_cnt;
    logic [4:0] next_tick_cnt;
    logic [3:0] channel;
    logic [3:0] next_channel;
    logic [11:0] result;
    logic [11:0] next_result;
    logic [3:0] result_chan;
    logic [3:0] next_result_chan;
    logic [31:0] next_prdata;

    // ==========================================
    // Bus decode
    logic wr;
    logic rd_setup;
    logic hit;
    logic wr_first;
    logic wr_second;
    ctrl_first_s wdata_first;
    ctrl_second_s wdata_second;
    flags_s wdata_flags;

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign hit = (paddr == `OFS_CTRL_FIRST) || (paddr == `OFS_CTRL_SECOND) ||
                 (paddr == `OFS_FLAGS) || (paddr == `OFS_MASK) ||
                 (paddr == `OFS_RESULT) || (paddr == `OFS_STATUS) ||
                 (paddr == `OFS_CLOCK_SYS);
    // Unmapped addresses answer with an error but never stall the bus
    assign pslverr = psel && penable && !hit;
    assign wr_first = wr && (paddr == `OFS_CTRL_FIRST);
    assign wr_second = wr && (paddr == `OFS_CTRL_SECOND);
    assign wdata_first.enable = pwdata[`BIT_ENABLE];
    assign wdata_first.power_on = pwdata[`BIT_POWER_ON];
    assign wdata_first.sample_timer = pwdata[`BIT_SAMPLE_TIMER];
    assign wdata_second = pwdata[6:0];
    assign wdata_flags = pwdata[3:0];

    // ==========================================
    // Converter clock and triggers
    logic clock_running;
    logic tick;
    logic timer_rise;
    logic single_mode;
    logic sw_start;
    logic timer_start;
    logic write_start;
    logic trig;
    logic can_start;
    logic odd_divider;
    logic hang_event;

    // A gated subsystem clock gives the converter no edges at all
    assign clock_running = ctrl_first.power_on && !hung &&
        !(ctrl_second.clock_select == `SUBSYS_CLOCK_SEL && gate_off);
    assign tick = clock_running && (div_cnt == ctrl_second.divider);
    assign timer_rise = timer_sync && !timer_prev;
    assign single_mode = (ctrl_second.seq_mode == SEQ_SINGLE);
    // A start may come from the very write that sets power and enable
    assign can_start = !halted && !hung &&
        (wr_first ? (wdata_first.power_on && wdata_first.enable) :
        (ctrl_first.power_on && ctrl_first.enable));

    // Software start needs enable and power set in the same write, with sample_timer clear
    assign sw_start = wr_first && pwdata[`BIT_SW_START] && wdata_first.enable &&
        wdata_first.power_on && !wdata_first.sample_timer;
    // Timer edges in single mode need a fresh arm from the enable bit
    assign timer_start = ctrl_first.sample_timer && timer_rise &&
        (!single_mode || armed);
    // Silicon defect kept on purpose: in single mode any timer-mode write that keeps enable high samples
    assign write_start = wr_first && single_mode && wdata_first.sample_timer &&
        wdata_first.enable && ctrl_first.enable;
    assign trig = sw_start || timer_start || write_start;

    // Divide by three, five, seven are field values 2, 4, 6
    assign odd_divider = (ctrl_second.divider == 3'h2) ||
        (ctrl_second.divider == 3'h4) || (ctrl_second.divider == 3'h6);
    assign hang_event = wr_second && gate_off && odd_divider &&
        (ctrl_second.clock_select == `SUBSYS_CLOCK_SEL) &&
        (wdata_second.clock_select != `SUBSYS_CLOCK_SEL);

    // ==========================================
    // Next-state logic
    always_comb begin
        flags_s set;
        flags_s clr;
        set = '0;
        clr = '0;
        next_ctrl_first = ctrl_first;
        next_ctrl_second = ctrl_second;
        next_mask = mask;
        next_gate_off = gate_off;
        next_armed = armed;
        next_halted = halted;
        next_hung = hung;
        next_state = state;
        next_div_cnt = div_cnt;
        next_tick_cnt = tick_cnt;
        next_channel = channel;
        next_result = result;
        next_result_chan = result_chan;

        // Register writes
        if (wr_first) begin
            next_ctrl_first = wdata_first;
            if (wdata_first.enable && !ctrl_first.enable) begin
                next_armed = 1'b1;
            end
            // Dropping power also clears a halt and any pending arm
            if (!wdata_first.power_on) begin
                next_halted = 1'b0;
                next_armed = 1'b0;
            end
        end
        if (wr_second) begin
            next_ctrl_second = wdata_second;
        end
        if (wr && paddr == `OFS_MASK) begin
            next_mask = wdata_flags;
        end
        if (wr && paddr == `OFS_FLAGS) begin
            clr = wdata_flags;
        end
        if (wr && paddr == `OFS_CLOCK_SYS) begin
            next_gate_off = pwdata[0];
        end

        // Converter clock divider
        // Parks at zero while stopped so a restarted clock begins a full period
        if (!clock_running || tick) begin
            next_div_cnt = 3'h0;
        end else begin
            next_div_cnt = div_cnt + 3'h1;
        end

        // Conversion sequencing
        unique case (state)
            ST_IDLE: begin
                if (trig && can_start) begin
                    next_state = ST_CONV;
                    next_tick_cnt = 5'h0;
                    next_armed = 1'b0;
                end
            end
            ST_CONV: begin
                if (trig && can_start) begin
                    if (!single_mode) begin
                        // Overlapping trigger kills the whole sequence
                        next_state = ST_IDLE;
                        next_halted = 1'b1;
                        set.halt = 1'b1;
                    end else begin
                        // Unreliable by design: set only on this one path
                        set.overflow = 1'b1;
                    end
                end else if (!ctrl_first.power_on) begin
                    next_state = ST_IDLE;
                end else if (tick) begin
                    // Result is taken on the last tick of the conversion
                    if (tick_cnt == `CONV_TICKS - 5'h1) begin
                        next_state = ST_IDLE;
                        next_result = sample_sync;
                        next_result_chan = channel;
                        set.done = 1'b1;
                        if (ctrl_second.seq_mode == SEQ_CHANNELS ||
                            ctrl_second.seq_mode == SEQ_REPEAT_CHANNELS) begin
                            if (channel == `LAST_CHANNEL) begin
                                next_channel = 4'h0;
                            end else begin
                                next_channel = channel + 4'h1;
                            end
                        end else begin
                            next_channel = 4'h0;
                        end
                    end else begin
                        next_tick_cnt = tick_cnt + 5'h1;
                    end
                end
            end
        endcase

        // Hang is sticky until reset; nothing written clears it
        if (hang_event) begin
            next_hung = 1'b1;
            next_state = ST_IDLE;
            set.hang = 1'b1;
        end

        // Set wins over a simultaneous write-one-to-clear
        next_flags = (flags & ~clr) | set;
    end

    // ==========================================
    // Read data, captured in the setup phase
    // Zero outside a read, so the bus shows nothing stale between transfers
    always_comb begin
        next_prdata = 32'h0;
        if (rd_setup) begin
            unique case (paddr)
                `OFS_CTRL_FIRST: begin
                    next_prdata[`BIT_ENABLE] = ctrl_first.enable;
                    next_prdata[`BIT_POWER_ON] = ctrl_first.power_on;
                    next_prdata[`BIT_SAMPLE_TIMER] = ctrl_first.sample_timer;
                end
                `OFS_CTRL_SECOND: begin
                    next_prdata[6:0] = ctrl_second;
                    next_prdata[`BIT_BUSY_MIRROR] = (state == ST_CONV);
                end
                `OFS_FLAGS: begin
                    next_prdata[3:0] = flags;
                end
                `OFS_MASK: begin
                    next_prdata[3:0] = mask;
                end
                `OFS_RESULT: begin
                    next_prdata[15:0] = {result_chan, result};
                end
                `OFS_STATUS: begin
                    next_prdata[3:0] = {armed, hung, halted, state == ST_CONV};
                end
                `OFS_CLOCK_SYS: begin
                    next_prdata[0] = gate_off;
                end
                default: begin
                    next_prdata = 32'h0;
                end
            endcase
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_first <= `RST_CTRL_FIRST;
            ctrl_second <= `RST_CTRL_SECOND;
            flags <= `RST_FLAGS;
            mask <= `RST_FLAGS;
            gate_off <= 1'b0;
            armed <= 1'b0;
            halted <= 1'b0;
            hung <= 1'b0;
            state <= ST_IDLE;
            // Low like the idle pin, so release of reset shows no false edge
            timer_prev <= 1'b0;
            div_cnt <= 3'h0;
            tick_cnt <= 5'h0;
            channel <= 4'h0;
            result <= 12'h000;
            result_chan <= 4'h0;
            prdata <= 32'h0;
        end else begin
            ctrl_first <= next_ctrl_first;
            ctrl_second <= next_ctrl_second;
            flags <= next_flags;
            mask <= next_mask;
            gate_off <= next_gate_off;
            armed <= next_armed;
            halted <= next_halted;
            hung <= next_hung;
            state <= next_state;
            timer_prev <= timer_sync;
            div_cnt <= next_div_cnt;
            tick_cnt <= next_tick_cnt;
            channel <= next_channel;
            result <= next_result;
            result_chan <= next_result_chan;
            prdata <= next_prdata;
        end
    end

    // ==========================================
    // Outputs
    // Plain state decode, so busy never lags the sequencer
    assign conv_busy = (state == ST_CONV);
    assign irq = |(flags & mask);

endmodule

/* File: testbench/adc_trig_asserts.sv */
`timescale 1ns/1ns
module adc_trig_asserts (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [7:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic conv_busy, // Busy
    input wire logic irq // Interrupt
);
    logic acc;
    logic mapped;
    logic [7:0] busy_cnt;
    logic [7:0] next_busy_cnt;
    assign acc = psel && penable;
    assign mapped = paddr[1:0] == 2'h0 && paddr <= 8'h18;
    // ==========================================
    // Busy length counter
    always_comb begin
        next_busy_cnt = conv_busy ? busy_cnt + 8'h01 : 8'h00;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt <= 8'h00;
        end else begin
            busy_cnt <= next_busy_cnt;
        end
    end
    // ==========================================
    // Checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence sw_start;
        acc && pwrite && paddr == 8'h00 && pwdata[3:0] == 4'h7 && !conv_busy;
    endsequence
    sequence mask_off;
        acc && pwrite && paddr == 8'h0c && pwdata[3:0] == 4'h0;
    endsequence
    sequence flags_wipe;
        acc && pwrite && paddr == 8'h08 && pwdata[3:0] == 4'hf && !conv_busy;
    endsequence
    a_ready_always: assert property (pready) else $error("ready low");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no error");
    a_err_mapped: assert property (!acc || mapped |-> !pslverr) else $error("bad error");
    a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped data");
    a_idle_data: assert property (!psel |-> prdata == 32'h0) else $error("idle data");
    a_start_busy: assert property (sw_start |-> ##[1:2] conv_busy)
        else $error("start ignored");
    a_busy_bounded: assert property (busy_cnt < 8'h8c) else $error("busy too long");
    a_mask_quiet: assert property (mask_off |-> ##[1:2] !irq) else $error("irq masked");
    a_wipe_quiet: assert property (flags_wipe |-> ##[1:2] !irq) else $error("irq cleared");
    a_reset_quiet: assert property ($rose(presetn) |-> !conv_busy && !irq)
        else $error("reset state");
endmodule

bind adc_conversion_trigger_control adc_trig_asserts adc_trig_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_busy(conv_busy), .irq(irq));

/* File: testbench/timer_source_model.sv */
`timescale 1ns/1ns
module timer_source_model #(
    parameter int GAP = 40
) (
    input wire logic pclk, // Clock
    input wire logic fire, // Request one trigger
    input wire logic [11:0] level, // Analog value to present
    output logic timer_trigger, // Timer output
    output logic [11:0] sample_in // Sample pins
);
    int since = GAP;
    initial timer_trigger = 1'b0;
    assign sample_in = level;
    // ==========================================
    // Trigger pulse, 3 cycles so the synchroniser cannot miss it
    always @(posedge pclk) begin
        since <= since + 1;
        if (fire && since >= GAP) begin
            timer_trigger <= 1'b1;
            since <= 0;
        end else if (since >= 2) begin
            timer_trigger <= 1'b0;
        end
    end
endmodule

/* File: testbench/test_adc_conversion_trigger_control.sv */
`timescale 1ns/1ns
module test_adc_conversion_trigger_control import adc_trig_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_q, q;
    logic pready, pslverr, timer_trigger, conv_busy, irq, err_q;
    logic fire = 1'b0;
    logic [11:0] sample_in;
    logic [11:0] level = 12'h5a3;
    int errors = 0;
    int checks = 0;

    always #50 pclk = ~pclk;

    adc_conversion_trigger_control adc_conversion_trigger_control_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_trigger(timer_trigger), .sample_in(sample_in), .conv_busy(conv_busy),
        .irq(irq));
    timer_source_model timer_source_model_i (
        .pclk(pclk), .fire(fire), .level(level), .timer_trigger(timer_trigger),
        .sample_in(sample_in));

    // ==========================================
    // Bus tasks
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            rd_q <= prdata;
            err_q <= pslverr;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        #1 q = rd_q;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge pclk);
        #1 chk({31'h0, irq}, {31'h0, e});
    endtask
    // Polling keeps the start spacing legal without assuming a latency
    task automatic wait_idle();
        for (int i = 0; i < 60; i++) begin
            apb(1'b0, 8'h14, 32'h0);
            if (q[0] === 1'b0) break;
        end
        chk({31'h0, q[0]}, 32'h0);
        chk({31'h0, conv_busy}, 32'h0);
    endtask
    task automatic pulse();
        repeat (40) @(posedge pclk);
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    task automatic test_done();
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================
    // Tests
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), 32'hffffffff, 32'h0);
            chk(32'(err_q), 32'(i == 7));
        end
        wr(8'h0c, 32'h1);
        wr(8'h00, 32'h7);
        chk({31'h0, conv_busy}, 32'h1);
        rd(8'h14, 32'h1, 32'h1);
        wait_idle();
        rd(8'h10, 32'hfff, 32'h5a3);
        rd(8'h08, 32'h1, 32'h1);
        irq_is(1'b1);
        wr(8'h0c, 32'h0);
        irq_is(1'b0);
        wr(8'h0c, 32'hf);
        irq_is(1'b1);
        wr(8'h08, 32'hf);
        irq_is(1'b0);
        wr(8'h00, 32'h4);
        wr(8'h00, 32'hd);
        rd(8'h14, 32'h9, 32'h8);
        pulse();
        rd(8'h14, 32'h9, 32'h1);
        wait_idle();
        pulse();
        rd(8'h14, 32'h1, 32'h0);
        wr(8'h00, 32'hd);
        rd(8'h14, 32'h1, 32'h1);
        wait_idle();
        wr(8'h00, 32'h4);
        rd(8'h14, 32'h1, 32'h0);
        wr(8'h00, 32'hd);
        rd(8'h14, 32'h9, 32'h8);
        wr(8'h08, 32'hf);
        wr(8'h00, 32'h4);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h7);
        wr(8'h00, 32'h7);
        rd(8'h14, 32'h3, 32'h2);
        rd(8'h08, 32'h4, 32'h4);
        wr(8'h00, 32'hd);
        pulse();
        rd(8'h14, 32'h3, 32'h2);
        wr(8'h00, 32'h4);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h4);
        wr(8'h00, 32'h5);
        wr(8'h00, 32'h7);
        rd(8'h14, 32'h3, 32'h1);
        wait_idle();
        wr(8'h08, 32'hf);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h7);
        wr(8'h00, 32'h7);
        wait_idle();
        rd(8'h08, 32'h5, 32'h1);
        wr(8'h08, 32'hf);
        wr(8'h04, 32'h2c);
        wr(8'h04, 32'h20);
        rd(8'h14, 32'h4, 32'h0);
        for (int d = 0; d < 8; d++) begin
            wr(8'h00, 32'h4);
            wr(8'h18, 32'h1);
            wr(8'h04, 32'(d * 16 + 12));
            wr(8'h04, 32'(d * 16));
            rd(8'h14, 32'h4, (d == 2 || d == 4 || d == 6) ? 32'h4 : 32'h0);
            wr(8'h00, 32'h0);
            wr(8'h00, 32'h4);
            rd(8'h14, 32'h4, (d == 2 || d == 4 || d == 6) ? 32'h4 : 32'h0);
            @(posedge pclk);
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
            rd(8'h14, 32'hf, 32'h0);
        end
        test_done();
    end
endmodule
